/* design/btn_if.sv */
/*
  Interface carrying debounced levels and edge pulses from the debouncer to the controller.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps

interface btn_if #(parameter int N = 18);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* design/manual_mode_ctrl.sv */
/*
  Manual override mode controller for an eight-channel contact-input module, with an
  AXI4-Lite register slave, telegram request port, LEDs and programming button.
  Assumes one 50 MHz clock, synchronous active-high reset at bus power-up, active-high
  pins, and a telegram sink that takes one request per tx_valid/tx_ready handshake.
*/
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "manual_mode_defs.svh"

module manual_mode_ctrl
  import manual_mode_pkg::*;
#(
  parameter int N_IN = 8,
  parameter logic [31:0] HOLD_CYCLES = `MS_TO_CYC(`HOLD_MS),
  parameter logic [31:0] FLASH_CYCLES = `MS_TO_CYC(`FLASH_MS),
  parameter logic [31:0] BLINK_CYCLES = `MS_TO_CYC(`BLINK_HALF_MS),
  parameter logic [31:0] DEBOUNCE_CYCLES = `MS_TO_CYC(`DEBOUNCE_MS),
  parameter logic [31:0] CYCLIC_CYCLES = `MS_TO_CYC(`CYCLIC_MS)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Front panel and contacts
  input wire logic [N_IN-1:0] contact_in,
  input wire logic [N_IN-1:0] key_in,
  input wire logic mode_btn_in,
  input wire logic prog_btn_in,
  output logic [N_IN-1:0] led_input,
  output logic led_manual,
  output logic led_prog,
  // Telegram requests
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [$clog2(N_IN)-1:0] tx_chan,
  output logic tx_value
);

  localparam int CHW = $clog2(N_IN);
  localparam int NB = 2 * N_IN + 2;
  localparam int MODE_BIT = 2 * N_IN;
  localparam int PROG_BIT = 2 * N_IN + 1;

  typedef struct packed {
    mode_t st;
    logic [31:0] hold_cnt;
    logic held;
    logic [31:0] flash_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [31:0] cyc_cnt;
    logic [N_IN-1:0] inp;
    logic [N_IN-1:0] pend;
    logic tx_v;
    logic [CHW-1:0] tx_ch;
    logic tx_val;
    logic prog;
    logic [15:0] paddr;
    logic man_en;
    logic inhibit;
    logic [N_IN-1:0] blk;
    logic [N_IN-1:0] cyc_en;
    logic [N_IN-1:0] ga;
    logic aw_got;
    logic [7:0] awa;
    logic w_got;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } ctrl_t;

  ctrl_t s_ff;
  ctrl_t nxt_s;

  btn_if #(.N(NB)) btn ();

  pin_debounce #(.N(NB), .STABLE_CYCLES(DEBOUNCE_CYCLES)) u_debounce (
    .clk(clk),
    .rst(rst),
    .raw({prog_btn_in, mode_btn_in, key_in, contact_in}),
    .clean(btn)
  );

  logic [N_IN-1:0] cont_lvl;
  logic [N_IN-1:0] key_rise;
  logic mode_lvl;
  logic en_ok;
  logic addr_wr;

  assign cont_lvl = btn.level[N_IN-1:0];
  assign key_rise = btn.rise[2*N_IN-1:N_IN];
  assign mode_lvl = btn.level[MODE_BIT];
  assign en_ok = s_ff.man_en && !s_ff.inhibit;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [CHW-1:0] lowest(input logic [N_IN-1:0] v);
    logic [CHW-1:0] r;
    r = '0;
    for (int i = N_IN - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = CHW'(i);
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `OFS_CTRL || a == `OFS_BLOCK || a == `OFS_GROUP ||
           a == `OFS_PHYS_ADDR || a == `OFS_STATUS;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] w;
    w = '0;
    nxt_s = s_ff;
    addr_wr = 1'b0;

    // Bus slave: address and data are caught in either order, then written together.
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_s.w_got = 1'b1;
      nxt_s.wd = s_axi_wdata;
      nxt_s.ws = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      nxt_s.bv = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got)
    begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bv = 1'b1;
      nxt_s.br = mapped(s_ff.awa) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_ff.awa)
        `OFS_CTRL:
        begin
          w = merge({30'h0, s_ff.inhibit, s_ff.man_en}, s_ff.wd, s_ff.ws);
          nxt_s.man_en = w[`CTRL_MAN_EN];
          nxt_s.inhibit = w[`CTRL_INHIBIT];
        end
        `OFS_BLOCK:
        begin
          w = merge({16'h0, s_ff.cyc_en, s_ff.blk}, s_ff.wd, s_ff.ws);
          nxt_s.blk = w[N_IN-1:0];
          nxt_s.cyc_en = w[`BLOCK_CYC_LSB +: N_IN];
        end
        `OFS_GROUP:
        begin
          w = merge({24'h0, s_ff.ga}, s_ff.wd, s_ff.ws);
          nxt_s.ga = w[N_IN-1:0];
        end
        `OFS_PHYS_ADDR:
        begin
          w = merge({16'h0, s_ff.paddr}, s_ff.wd, s_ff.ws);
          nxt_s.paddr = w[15:0];
          addr_wr = 1'b1;
        end
        default:
        begin
          w = '0;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      nxt_s.rv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_s.rv = 1'b1;
      nxt_s.rr = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_CTRL: nxt_s.rd = {30'h0, s_ff.inhibit, s_ff.man_en};
        `OFS_BLOCK: nxt_s.rd = {16'h0, s_ff.cyc_en, s_ff.blk};
        `OFS_GROUP: nxt_s.rd = {24'h0, s_ff.ga};
        `OFS_PHYS_ADDR: nxt_s.rd = {16'h0, s_ff.paddr};
        `OFS_STATUS: nxt_s.rd = {16'h0, s_ff.inp, 6'h00, s_ff.prog, s_ff.st == ST_MAN};
        default: nxt_s.rd = '0;
      endcase
    end

    // The press toggles; an address assigned in the same cycle loses to the press.
    if (btn.rise[PROG_BIT])
    begin
      nxt_s.prog = !s_ff.prog;
    end
    else if (addr_wr)
    begin
      nxt_s.prog = 1'b0;
    end

    // Flash divider.
    if (s_ff.blink_cnt >= BLINK_CYCLES - 32'd1)
    begin
      nxt_s.blink_cnt = '0;
      nxt_s.blink = !s_ff.blink;
    end
    else
    begin
      nxt_s.blink_cnt = s_ff.blink_cnt + 32'd1;
    end

    // Press timing; one trigger per press, released presses just reset the count.
    if (mode_lvl)
    begin
      if (s_ff.hold_cnt < HOLD_CYCLES)
      begin
        nxt_s.hold_cnt = s_ff.hold_cnt + 32'd1;
      end
    end
    else
    begin
      nxt_s.hold_cnt = '0;
      nxt_s.held = 1'b0;
    end

    // The request slot is refilled before new events are merged, so a set always wins.
    if (s_ff.tx_v && tx_ready)
    begin
      nxt_s.tx_v = 1'b0;
    end
    if (!s_ff.tx_v && |s_ff.pend)
    begin
      nxt_s.tx_v = 1'b1;
      nxt_s.tx_ch = lowest(s_ff.pend);
      nxt_s.tx_val = s_ff.inp[lowest(s_ff.pend)];
      nxt_s.pend[lowest(s_ff.pend)] = 1'b0;
    end

    if (s_ff.cyc_cnt >= CYCLIC_CYCLES - 32'd1)
    begin
      nxt_s.cyc_cnt = '0;
      nxt_s.pend = nxt_s.pend | (s_ff.cyc_en & s_ff.ga);
    end
    else
    begin
      nxt_s.cyc_cnt = s_ff.cyc_cnt + 32'd1;
    end

    unique case (s_ff.st)
      ST_BUS, ST_MAN:
      begin
        if (mode_lvl && !s_ff.held && s_ff.hold_cnt == HOLD_CYCLES - 32'd1)
        begin
          nxt_s.held = 1'b1;
          nxt_s.flash_cnt = '0;
          if (s_ff.st == ST_MAN)
          begin
            nxt_s.st = ST_FLASH_TO_BUS;
          end
          else if (en_ok)
          begin
            nxt_s.st = ST_FLASH_TO_MAN;
          end
        end
      end
      ST_FLASH_TO_MAN, ST_FLASH_TO_BUS:
      begin
        nxt_s.flash_cnt = s_ff.flash_cnt + 32'd1;
        if (s_ff.flash_cnt == FLASH_CYCLES - 32'd1)
        begin
          nxt_s.st = (s_ff.st == ST_FLASH_TO_MAN) ? ST_MAN : ST_BUS;
        end
      end
    endcase

    if (s_ff.st == ST_MAN)
    begin
      // Contacts are not looked at; keys work regardless of block.
      nxt_s.inp = s_ff.inp ^ key_rise;
      nxt_s.pend = nxt_s.pend | (key_rise & s_ff.ga);
    end
    else if (s_ff.st == ST_FLASH_TO_BUS && s_ff.flash_cnt == FLASH_CYCLES - 32'd1)
    begin
      nxt_s.inp = cont_lvl;
      nxt_s.pend = nxt_s.pend | s_ff.ga;
    end
    else if (s_ff.st != ST_FLASH_TO_BUS)
    begin
      // Blocked inputs keep their last value; keys are not looked at here.
      nxt_s.inp = (s_ff.inp & s_ff.blk) | (cont_lvl & ~s_ff.blk);
      nxt_s.pend = nxt_s.pend | ((cont_lvl ^ s_ff.inp) & ~s_ff.blk & s_ff.ga);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.st <= ST_BUS;
      s_ff.paddr <= `PHYS_ADDR_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = !s_ff.aw_got && !s_ff.bv;
  assign s_axi_wready = !s_ff.w_got && !s_ff.bv;
  assign s_axi_bvalid = s_ff.bv;
  assign s_axi_bresp = s_ff.br;
  assign s_axi_arready = !s_ff.rv;
  assign s_axi_rvalid = s_ff.rv;
  assign s_axi_rdata = s_ff.rd;
  assign s_axi_rresp = s_ff.rr;
  assign led_input = s_ff.inp;
  assign led_prog = s_ff.prog;
  assign tx_valid = s_ff.tx_v;
  assign tx_chan = s_ff.tx_ch;
  assign tx_value = s_ff.tx_val;

  // A press that cannot change the mode leaves the LED alone.
  always_comb
  begin
    unique case (s_ff.st)
      ST_BUS: led_manual = mode_lvl && en_ok && !s_ff.held && s_ff.blink;
      ST_MAN: led_manual = (mode_lvl && !s_ff.held) ? s_ff.blink : 1'b1;
      ST_FLASH_TO_MAN, ST_FLASH_TO_BUS: led_manual = s_ff.blink;
    endcase
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_keys_ignored_in_bus;
    (s_ff.st == ST_BUS && cont_lvl == s_ff.inp && |key_rise) |=> s_ff.inp == $past(s_ff.inp);
  endproperty
  a_keys_ignored_in_bus: assert property (p_keys_ignored_in_bus)
    else $error("keypad changed an input in bus mode");

  property p_no_enable_no_change;
    (s_ff.st == ST_BUS && !en_ok) |=> s_ff.st == ST_BUS;
  endproperty
  a_no_enable_no_change: assert property (p_no_enable_no_change)
    else $error("mode left bus operation while not enabled");

  property p_short_press;
    (s_ff.st == ST_BUS && mode_lvl && s_ff.hold_cnt < HOLD_CYCLES - 32'd1) |=> s_ff.st == ST_BUS;
  endproperty
  a_short_press: assert property (p_short_press)
    else $error("mode changed before the hold time");

  // The frozen value is the last real sample taken in the flash cycle before the commit.
  property p_freeze_on_entry;
    (s_ff.st == ST_FLASH_TO_MAN ##1 s_ff.st == ST_MAN)
      |-> s_ff.inp == (($past(s_ff.inp) & $past(s_ff.blk)) |
                       ($past(cont_lvl) & ~$past(s_ff.blk)));
  endproperty
  a_freeze_on_entry: assert property (p_freeze_on_entry)
    else $error("inputs not frozen at switchover");

  property p_manual_hold;
    (s_ff.st == ST_MAN && !(|key_rise)) |=> s_ff.st != ST_MAN || s_ff.inp == $past(s_ff.inp);
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("input changed in manual mode without a key");

  property p_flash_length;
    (s_ff.st == ST_FLASH_TO_BUS || s_ff.st == ST_FLASH_TO_MAN) |-> s_ff.flash_cnt < FLASH_CYCLES;
  endproperty
  a_flash_length: assert property (p_flash_length)
    else $error("flash phase ran past its length");

  property p_exit_refresh;
    (s_ff.st == ST_FLASH_TO_BUS && s_ff.flash_cnt == FLASH_CYCLES - 32'd1)
      |=> s_ff.st == ST_BUS && s_ff.inp == $past(cont_lvl) &&
          ((s_ff.pend | (s_ff.tx_v ? (N_IN'(1) << s_ff.tx_ch) : '0)) & $past(s_ff.ga)) ==
          $past(s_ff.ga);
  endproperty
  a_exit_refresh: assert property (p_exit_refresh)
    else $error("leaving manual mode did not refresh inputs");

  property p_prog_on;
    (btn.rise[PROG_BIT] && !s_ff.prog) |=> led_prog;
  endproperty
  a_prog_on: assert property (p_prog_on)
    else $error("programming LED did not light");

  property p_prog_off;
    (addr_wr && !btn.rise[PROG_BIT]) |=> !led_prog;
  endproperty
  a_prog_off: assert property (p_prog_off)
    else $error("programming LED stayed on after address write");

  property p_block_holds;
    (s_ff.st == ST_BUS)
      |=> s_ff.st != ST_BUS || ((s_ff.inp ^ $past(s_ff.inp)) & $past(s_ff.blk)) == '0;
  endproperty
  a_block_holds: assert property (p_block_holds)
    else $error("blocked input followed its contact");

  c_enter_manual: cover property (s_ff.st == ST_FLASH_TO_MAN ##1 s_ff.st == ST_MAN);
  c_leave_manual: cover property (s_ff.st == ST_FLASH_TO_BUS ##1 s_ff.st == ST_BUS);
  c_tx_taken: cover property (tx_valid && tx_ready);
  c_prog_toggle: cover property (led_prog ##1 !led_prog);

endmodule

/* design/manual_mode_defs.svh */
/*
  Constants for the manual override mode controller: register offsets, field positions,
  reset values, bus response codes and timing figures.
  Assumes a 50 MHz system clock; included by bare name from the design files.
*/
`ifndef MANUAL_MODE_DEFS_SVH
`define MANUAL_MODE_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_KHZ 50000
`define HOLD_MS 2000
`define FLASH_MS 3000
`define BLINK_HALF_MS 125
`define DEBOUNCE_MS 10
`define CYCLIC_MS 10000
`define MS_TO_CYC(ms) ((ms) * `CLK_KHZ)

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_BLOCK 8'h04
`define OFS_GROUP 8'h08
`define OFS_PHYS_ADDR 8'h0C
`define OFS_STATUS 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_MAN_EN 0
`define CTRL_INHIBIT 1
`define BLOCK_CYC_LSB 8
`define STAT_MANUAL 0
`define STAT_PROG 1
`define STAT_INPUT_LSB 8

// ----------------------------------------------------------------------
// Reset values and bus responses
// ----------------------------------------------------------------------
`define PHYS_ADDR_RST 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* design/manual_mode_pkg.sv */
/*
  Types shared by the manual override mode controller files.
  Assumes nothing of its surroundings.
*/
package manual_mode_pkg;

  // Operating state of the mode controller.
  typedef enum logic [1:0] {ST_BUS, ST_FLASH_TO_MAN, ST_MAN, ST_FLASH_TO_BUS} mode_t;

endpackage

/* design/pin_debounce.sv */
/*
  Three-stage synchroniser and debouncer for a group of pin inputs.
  Assumes raw pins are asynchronous to clk and active high.
*/
`timescale 1ns/100ps

module pin_debounce #(
  parameter int N = 18,
  parameter logic [31:0] STABLE_CYCLES = 32'd500000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and clean output
  input wire logic [N-1:0] raw,
  btn_if.src clean
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0][31:0] cnt;
  } deb_t;

  deb_t s_ff;
  deb_t nxt_s;

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  // A level is accepted only once stages two and three agree and stay different from the
  // accepted level for the whole stable time; the first stage feeds only the second.
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.s1 = raw;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.rise = '0;
    nxt_s.fall = '0;
    for (int i = 0; i < N; i++)
    begin
      if (s_ff.s2[i] == s_ff.s3[i] && s_ff.s3[i] != s_ff.lvl[i])
      begin
        if (s_ff.cnt[i] >= STABLE_CYCLES - 32'd1)
        begin
          nxt_s.cnt[i] = '0;
          nxt_s.lvl[i] = s_ff.s3[i];
          nxt_s.rise[i] = s_ff.s3[i];
          nxt_s.fall[i] = !s_ff.s3[i];
        end
        else
        begin
          nxt_s.cnt[i] = s_ff.cnt[i] + 32'd1;
        end
      end
      else
      begin
        nxt_s.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign clean.level = s_ff.lvl;
  assign clean.rise = s_ff.rise;
  assign clean.fall = s_ff.fall;

endmodule

/* tb/manual_mode_ctrl_bench.sv */
/*
  Self-checking bench for the manual override mode controller.
  Assumes a 50 MHz clock, the telegram sink model, and shortened count parameters.
*/
`timescale 1ns/100ps
`include "manual_mode_defs.svh"

module manual_mode_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, bv, arr, rv, led_m, led_p, txv, txr;
  logic [1:0] br, rr, r;
  logic [31:0] rdt, d;
  logic [7:0] cin = 8'h00;
  logic [9:0] btn = 10'h000;
  logic [7:0] led_in, ex;
  logic [3:0] ws = 4'hF;
  logic [2:0] tch, lch;
  logic tval, lval;
  int n_fail = 0, tests_run = 0, cyc = 0, nt = 0, n_taken;

  always #10 clk = ~clk;

  manual_mode_ctrl #(.HOLD_CYCLES(32'h14), .FLASH_CYCLES(32'h1E), .BLINK_CYCLES(32'h2),
    .DEBOUNCE_CYCLES(32'h2), .CYCLIC_CYCLES(32'hBB8)) DUT (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .contact_in(cin), .key_in(btn[7:0]), .mode_btn_in(btn[8]), .prog_btn_in(btn[9]),
    .led_input(led_in), .led_manual(led_m), .led_prog(led_p),
    .tx_valid(txv), .tx_ready(txr), .tx_chan(tch), .tx_value(tval));

  tg_sink SINK (.clk(clk), .rst(rst), .tx_valid(txv), .tx_ready(txr), .n_taken(n_taken));

  // The last telegram taken is kept so that its channel and value can be compared.
  always @(posedge clk)
  begin
    if (txv && txr)
    begin
      lch <= tch;
      lval <= tval;
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The trailing edge keeps the next call from assigning a ready in the same step.
  task wr(input logic [7:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    while (!bv);
    r = br;
    bry <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    d = rdt;
    r = rr;
    rry <= 1'b0;
    @(posedge clk);
  endtask

  // A press is held n cycles, then time is left for debounce, flash and telegrams.
  task push(input logic [9:0] m, input int n);
    btn <= m;
    repeat (n) @(posedge clk);
    btn <= 10'h000;
    repeat (100) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(61100));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_PHYS_ADDR); chk(d, 32'h0000FFFF);
    rd(`OFS_STATUS); chk(d, 32'h0);
    chk(32'(led_m), 32'h0);
    rd(8'h14); chk({30'h0, r}, 32'h2);
    wr(8'h18, 32'h1); chk({30'h0, r}, 32'h2);
    wr(`OFS_GROUP, 32'hFF);
    ws <= 4'h2;
    wr(`OFS_GROUP, 32'h0);
    ws <= 4'hF;
    rd(`OFS_GROUP); chk(d, 32'h000000FF);
    ex = 8'($urandom);
    cin <= ex;
    nt += $countones(ex);
    repeat (80) @(posedge clk);
    chk(32'(led_in), 32'(ex));
    chk(32'(n_taken), 32'(nt));
    push(10'h0FF, 6);
    chk(32'(led_in), 32'(ex));
    chk(32'(n_taken), 32'(nt));
    for (int c = 0; c < 4; c += 3)
    begin
      wr(`OFS_CTRL, 32'(c));
      push(10'h100, 30);
      rd(`OFS_STATUS); chk(32'(d[0]), 32'h0);
    end
    wr(`OFS_CTRL, 32'h1);
    push(10'h100, 8);
    rd(`OFS_STATUS); chk(32'(d[0]), 32'h0);
    chk(32'(led_m), 32'h0);
    wr(`OFS_BLOCK, 32'h1);
    cin <= ex ^ 8'h01;
    repeat (30) @(posedge clk);
    chk(32'(led_in), 32'(ex));
    chk(32'(n_taken), 32'(nt));
    push(10'h100, 30);
    rd(`OFS_STATUS); chk(d, {16'h0, ex, 8'h01});
    chk(32'(led_m), 32'h1);
    cin <= ~ex;
    repeat (30) @(posedge clk);
    chk(32'(led_in), 32'(ex));
    push(10'h001, 6);
    ex ^= 8'h01;
    nt++;
    chk(32'(led_in), 32'(ex));
    chk(32'(n_taken), 32'(nt));
    chk(32'(lch), 32'h0);
    chk(32'(lval), 32'(ex[0]));
    wr(`OFS_BLOCK, 32'h0);
    push(10'h100, 30);
    repeat (60) @(posedge clk);
    nt += 8;
    chk(32'(led_in), 32'(cin));
    chk(32'(n_taken), 32'(nt));
    chk(32'(lch), 32'h7);
    chk(32'(lval), 32'(cin[7]));
    chk(32'(led_m), 32'h0);
    push(10'h200, 6);
    chk(32'(led_p), 32'h1);
    wr(`OFS_PHYS_ADDR, 32'h1234);
    chk(32'(led_p), 32'h0);
    rd(`OFS_PHYS_ADDR); chk(d, 32'h1234);
    push(10'h200, 6);
    push(10'h200, 6);
    chk(32'(led_p), 32'h0);
    // Both writes take equally long, so cyclic sending is on for exactly one period.
    wr(`OFS_BLOCK, 32'h0101);
    repeat (2996) @(posedge clk);
    wr(`OFS_BLOCK, 32'h0001);
    repeat (40) @(posedge clk);
    nt++;
    chk(32'(n_taken), 32'(nt));
    chk(32'(lch), 32'h0);
    chk(32'(lval), 32'(cin[0]));
    give_verdict;
  end
endmodule

/* tb/tg_sink.sv */
/*
  Telegram sink standing in for the fieldbus side of the mode controller.
  Assumes the controller holds tx_valid until it sees tx_ready at a rising edge.
*/
`timescale 1ns/100ps

module tg_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Telegram handshake
  input wire logic tx_valid,
  output logic tx_ready,
  output int n_taken
);
  // Ready stalls at random so that queued events must wait and merge.
  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_ready <= 1'b0;
      n_taken <= 0;
    end
    else
    begin
      if (tx_valid && tx_ready)
        n_taken <= n_taken + 1;
      tx_ready <= 1'($urandom % 2);
    end
  end
endmodule
